// File: verilog/touch_pkg.sv
`default_nettype none
package touch_pkg;
    // Sensor population: six buttons, one proximity, one guard
    localparam int NUM_SENS = 8;
    localparam int RAW_W = 16;
    localparam logic [7:0] BUTTON_MASK = 8'h3f;
    localparam logic [7:0] PROX_MASK = 8'h40;
    localparam int GUARD_IDX = 7;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SENS = 8'h04;
    localparam logic [7:0] ADDR_FEAT = 8'h08;
    localparam logic [7:0] ADDR_THR = 8'h0c;
    localparam logic [7:0] ADDR_HOLD_EN = 8'h10;
    localparam logic [7:0] ADDR_HOLD_LO = 8'h14;
    localparam logic [7:0] ADDR_HOLD_HI = 8'h18;
    localparam logic [7:0] ADDR_STAT = 8'h20;
    localparam logic [7:0] ADDR_LATCH = 8'h24;
    localparam logic [7:0] ADDR_NOISE = 8'h28;

    // Control register fields and reset value
    localparam int CTRL_AUTO_THR = 0;
    localparam int CTRL_NOISE_IMM = 1;
    localparam int CTRL_ARST_BTN = 2;
    localparam int CTRL_ARST_PROX = 3;
    localparam int CTRL_THR_OVR = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h01;
    localparam int FEAT_TOGGLE_LSB = 8;
    localparam int HOLD_FIELD_W = 8;

    // Threshold arithmetic
    localparam logic [15:0] SENS_STEP_COUNTS = 16'h0010;
    localparam int NOISE_SHIFT = 2;

    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_MS = 20;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int ARST_SHORT_S = 5;
    localparam int ARST_LONG_S = 20;
    localparam logic [9:0] ARST_SHORT_TICKS = 10'(ARST_SHORT_S * 1000 / TICK_MS);
    localparam logic [9:0] ARST_LONG_TICKS = 10'(ARST_LONG_S * 1000 / TICK_MS);
    localparam int HOLD_MAX_MS = 2000;
    localparam logic [6:0] HOLD_MAX_STEPS = 7'(HOLD_MAX_MS / TICK_MS);
    localparam int HOST_INT_NS = 1000;
    localparam logic [7:0] HOST_INT_CYCLES =
        8'((HOST_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Pseudo-random sense clock
    localparam logic [15:0] SEQ_SEED = 16'hace1;
    localparam logic [15:0] SEQ_TAPS = 16'hb400;

    // Filter strengths
    localparam int BTN_IIR_SHIFT = 2;
    localparam int PROX_LP_SHIFT = 4;
endpackage : touch_pkg
`default_nettype wire

// File: verilog/sensor_filter.sv
`timescale 1ns/100ps
`default_nettype none
module sensor_filter (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Sample in
    input wire logic i_valid,
    input wire logic [15:0] i_raw,
    input wire logic i_prox,
    input wire logic i_noise_imm,
    // Filtered out
    output logic [15:0] o_filt
);
    logic [15:0] s1;
    logic [15:0] s2;
    logic primed;
    logic [15:0] med;
    logic [15:0] src;
    logic [15:0] step;
    int sh;

    // Median of three, skipped for proximity which uses the slow low-pass
    always_comb begin
        if ((i_raw >= s1) == (i_raw <= s2)) med = i_raw;
        else if ((s1 >= i_raw) == (s1 <= s2)) med = s1;
        else med = s2;
        src = i_prox ? i_raw : med;
        sh = i_prox ? touch_pkg::PROX_LP_SHIFT : touch_pkg::BTN_IIR_SHIFT;
        if (i_noise_imm) sh = sh + 1; // Heavier smoothing costs response time
        step = (src >= o_filt) ? (src - o_filt) >> sh : (o_filt - src) >> sh;
    end

    // Sample history for the median
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1 <= 16'h0000;
            s2 <= 16'h0000;
        end else if (i_valid) begin
            s1 <= primed ? i_raw : i_raw;
            s2 <= primed ? s1 : i_raw;
        end
    end

    // IIR output; the first sample loads directly to avoid a long ramp
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_filt <= 16'h0000;
            primed <= 1'b0;
        end else if (i_valid) begin
            primed <= 1'b1;
            if (!primed) o_filt <= i_raw;
            else if (src >= o_filt) o_filt <= o_filt + step;
            else o_filt <= o_filt - step;
        end
    end
endmodule : sensor_filter
`default_nettype wire

// File: verilog/touch_status_postprocess.sv
// Behaviour
// - Auto threshold derives button thresholds from noise; sliders and proximity untouched.
// - A control bit turns auto threshold on or off.
// - Noise immunity mode on forces auto threshold off.
// - A written threshold overrides the automatic one.
// - Every button and slider has its own sensitivity setting.
// - Sensitivity is two bits: 0.1, 0.2, 0.3 or 0.4 pF.
// - Sensor active for the auto reset period goes off, baseline reloads raw.
// - Auto reset period is 5 or 20 seconds.
// - One period setting for proximity, another for buttons and sliders.
// - The guard sensor never auto resets.
// - Per-button adjacent-touch suppression enable, buttons only.
// - Among suppressed buttons only the earliest touched reports active; the code breaks ties and re-elects after a release by lowest touched index.
// - Sensing clock comes from a pseudo-random sequence.
// - Buttons and sliders get median and IIR filtering.
// - Proximity sensors get a dedicated low-pass filter.
// - Noise immunity mode can be switched off.
// - Activations latch until the host reads them.
// - Any reported status change raises the host interrupt.
// - Toggle mode inverts the status on each new activation.
// - Hold-on keeps the general output on after release.
// - Hold-on is 0 to 2 s in 20 ms steps; not in toggle or after reset.
`timescale 1ns/100ps
`default_nettype none
module touch_status_postprocess #(
    parameter int TICK_CYCLES = touch_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Measurement front end
    input wire logic i_scan_done,
    input wire logic [127:0] i_raw_count,
    output logic o_pseudo_random_sense_clock,
    output logic o_advanced_noise_immunity_mode,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Outputs to pins
    output logic [7:0] o_general_output_pin,
    output logic o_host_int_n
);
    localparam int N = touch_pkg::NUM_SENS;

    typedef enum logic {PH_INIT, PH_RUN} phase_e;

    phase_e phase;
    logic [touch_pkg::CTRL_W-1:0] ctrl;
    logic [15:0] sens_cfg;
    logic [7:0] adjacent_touch_suppression;
    logic [7:0] toggle_en;
    logic [15:0] thr_ovr;
    logic [7:0] hold_en;
    logic [6:0] hold_time [N];
    logic [15:0] filt [N];
    logic [15:0] baseline [N];
    logic [15:0] thr [N];
    logic [15:0] diff [N];
    logic [9:0] arst_cnt [N];
    logic [6:0] hold_cnt [N];
    logic [7:0] det;
    logic [7:0] det_q;
    logic [7:0] arst_fire;
    logic [7:0] reported;
    logic [7:0] next_reported;
    logic [7:0] tog;
    logic [7:0] next_stat;
    logic [7:0] cur_stat;
    logic [7:0] latched;
    logic [15:0] noise_est;
    logic [15:0] next_noise;
    logic [2:0] owner;
    logic owner_v;
    logic [2:0] next_owner;
    logic next_owner_v;
    logic [7:0] cand;
    logic auto_active;
    logic [31:0] tick_cnt;
    logic tick;
    logic [15:0] lfsr;
    logic [7:0] int_cnt;
    logic latch_rd;

    // Sensitivity code to counts, 0.1 pF per step
    function automatic logic [15:0] sens_thr(input logic [1:0] code);
        sens_thr = 16'(touch_pkg::SENS_STEP_COUNTS * (32'(code) + 1));
    endfunction : sens_thr

    // Register decode shared by write and read side
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign latch_rd = i_rd && hit(i_addr, touch_pkg::ADDR_LATCH);
    assign o_advanced_noise_immunity_mode = ctrl[touch_pkg::CTRL_NOISE_IMM];
    // Noise immunity wins over auto threshold
    assign auto_active = ctrl[touch_pkg::CTRL_AUTO_THR]
        && !ctrl[touch_pkg::CTRL_NOISE_IMM];

    // Configuration writes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl <= touch_pkg::CTRL_RESET;
            sens_cfg <= 16'h0000;
            adjacent_touch_suppression <= 8'h00;
            toggle_en <= 8'h00;
            thr_ovr <= 16'h0000;
            hold_en <= 8'h00;
        end else if (i_wr) begin
            if (hit(i_addr, touch_pkg::ADDR_CTRL))
                ctrl <= i_wdata[touch_pkg::CTRL_W-1:0];
            if (hit(i_addr, touch_pkg::ADDR_SENS))
                sens_cfg <= i_wdata[15:0];
            if (hit(i_addr, touch_pkg::ADDR_FEAT)) begin
                // Suppression only exists on buttons
                adjacent_touch_suppression <= i_wdata[7:0] & touch_pkg::BUTTON_MASK;
                toggle_en <= i_wdata[touch_pkg::FEAT_TOGGLE_LSB +: 8];
            end
            if (hit(i_addr, touch_pkg::ADDR_THR))
                thr_ovr <= i_wdata[15:0];
            if (hit(i_addr, touch_pkg::ADDR_HOLD_EN))
                hold_en <= i_wdata[7:0];
        end
    end

    // Hold times, four per word, clamped to 2 s
    generate
        for (genvar g = 0; g < N; g++) begin : g_hold_cfg
            localparam logic [7:0] HADDR = (g < 4) ? touch_pkg::ADDR_HOLD_LO
                                                   : touch_pkg::ADDR_HOLD_HI;
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) hold_time[g] <= 7'h00;
                else if (i_wr && hit(i_addr, HADDR)) begin
                    if (i_wdata[(g % 4) * touch_pkg::HOLD_FIELD_W +: 7] > touch_pkg::HOLD_MAX_STEPS)
                        hold_time[g] <= touch_pkg::HOLD_MAX_STEPS;
                    else
                        hold_time[g] <= i_wdata[(g % 4) * touch_pkg::HOLD_FIELD_W +: 7];
                end
            end
        end
    endgenerate

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) o_rdata <= 32'h00000000;
        else if (i_rd) begin
            case (i_addr)
                touch_pkg::ADDR_CTRL: o_rdata <= 32'(ctrl);
                touch_pkg::ADDR_SENS: o_rdata <= 32'(sens_cfg);
                touch_pkg::ADDR_FEAT: o_rdata <= {16'h0000, toggle_en, adjacent_touch_suppression};
                touch_pkg::ADDR_THR: o_rdata <= 32'(thr_ovr);
                touch_pkg::ADDR_HOLD_EN: o_rdata <= 32'(hold_en);
                touch_pkg::ADDR_HOLD_LO: o_rdata <= {1'b0, hold_time[3], 1'b0, hold_time[2],
                                                     1'b0, hold_time[1], 1'b0, hold_time[0]};
                touch_pkg::ADDR_HOLD_HI: o_rdata <= {1'b0, hold_time[7], 1'b0, hold_time[6],
                                                     1'b0, hold_time[5], 1'b0, hold_time[4]};
                touch_pkg::ADDR_STAT: o_rdata <= {16'h0000, det_q, cur_stat};
                touch_pkg::ADDR_LATCH: o_rdata <= 32'(latched);
                touch_pkg::ADDR_NOISE: o_rdata <= {15'h0000, auto_active, noise_est};
                default: o_rdata <= 32'h00000000;
            endcase
        end
    end

    // Free-running pseudo-random sequence spreads sense clock emissions
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) lfsr <= touch_pkg::SEQ_SEED;
        else lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? touch_pkg::SEQ_TAPS : 16'h0000);
    end
    assign o_pseudo_random_sense_clock = lfsr[0];

    // 20 ms time base for auto reset and hold-on
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt <= 32'h00000000;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h00000000 : tick_cnt + 1;
        end
    end

    // Baseline capture happens once on the first scan
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) phase <= PH_INIT;
        else begin
            case (phase)
                PH_INIT: if (i_scan_done) phase <= PH_RUN;
                PH_RUN: phase <= PH_RUN;
                default: phase <= PH_INIT;
            endcase
        end
    end

    // Per-sensor filtering, thresholds and timers
    generate
        for (genvar g = 0; g < N; g++) begin : g_sens
            localparam bit IS_BTN = touch_pkg::BUTTON_MASK[g];
            localparam bit IS_PROX = touch_pkg::PROX_MASK[g];

            sensor_filter u_filt (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_valid(i_scan_done),
                .i_raw(i_raw_count[g*16 +: 16]),
                .i_prox(IS_PROX),
                .i_noise_imm(o_advanced_noise_immunity_mode),
                .o_filt(filt[g])
            );

            // Button thresholds follow the override, else noise while auto threshold is active; all other cases use sensitivity
            always_comb begin
                thr[g] = sens_thr(sens_cfg[2*g +: 2]);
                if (IS_BTN && ctrl[touch_pkg::CTRL_THR_OVR]) thr[g] = thr_ovr;
                else if (IS_BTN && auto_active)
                    thr[g] = (noise_est << touch_pkg::NOISE_SHIFT)
                             + touch_pkg::SENS_STEP_COUNTS;
                diff[g] = (filt[g] > baseline[g]) ? filt[g] - baseline[g] : 16'h0000;
                det[g] = (phase == PH_RUN) && (diff[g] > thr[g]);
            end

            // Stuck sensor check once per scan; the guard is exempt
            assign arst_fire[g] = i_scan_done && det_q[g] && (g != touch_pkg::GUARD_IDX)
                && (arst_cnt[g] >= ((IS_PROX ? ctrl[touch_pkg::CTRL_ARST_PROX]
                                             : ctrl[touch_pkg::CTRL_ARST_BTN])
                    ? touch_pkg::ARST_LONG_TICKS : touch_pkg::ARST_SHORT_TICKS));

            // Active time counter, cleared when inactive or after a reset
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) arst_cnt[g] <= 10'h000;
                else if (!det_q[g] || arst_fire[g]) arst_cnt[g] <= 10'h000;
                else if (tick && arst_cnt[g] != 10'h3ff) arst_cnt[g] <= arst_cnt[g] + 10'h001;
            end

            // Baseline: raw on start and on auto reset, tracks filter when idle
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) baseline[g] <= 16'h0000;
                else if (i_scan_done) begin
                    if (phase == PH_INIT || arst_fire[g])
                        baseline[g] <= i_raw_count[g*16 +: 16];
                    else if (!det[g]) baseline[g] <= filt[g];
                end
            end

            // Hold-on: loads at release unless toggled or auto reset
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) hold_cnt[g] <= 7'h00;
                else if (i_scan_done && next_reported[g]) hold_cnt[g] <= 7'h00;
                else if (i_scan_done && reported[g] && hold_en[g] && !toggle_en[g]
                         && !arst_fire[g]) hold_cnt[g] <= hold_time[g];
                else if (tick && hold_cnt[g] != 7'h00) hold_cnt[g] <= hold_cnt[g] - 7'h01;
            end
        end
    endgenerate

    // Suppression owner: keep the holder, else lowest touched candidate index
    always_comb begin
        cand = det & ~arst_fire & adjacent_touch_suppression;
        next_owner = owner;
        next_owner_v = 1'b0;
        if (owner_v && cand[owner]) next_owner_v = 1'b1;
        else begin
            for (int i = N - 1; i >= 0; i--) begin
                if (cand[i]) begin
                    next_owner = 3'(i);
                    next_owner_v = 1'b1;
                end
            end
        end
        next_reported = det & ~arst_fire & ~adjacent_touch_suppression;
        if (next_owner_v) next_reported[next_owner] = 1'b1;
        // Toggle flips on each rising activation
        next_stat = toggle_en & (tog ^ (next_reported & ~reported));
        next_stat = next_stat | (~toggle_en & next_reported);
    end

    // Per-scan status update
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            det_q <= 8'h00;
            reported <= 8'h00;
            tog <= 8'h00;
            cur_stat <= 8'h00;
            owner <= 3'h0;
            owner_v <= 1'b0;
        end else if (i_scan_done) begin
            det_q <= det & ~arst_fire;
            reported <= next_reported;
            tog <= tog ^ (next_reported & ~reported);
            cur_stat <= next_stat;
            owner <= next_owner;
            owner_v <= next_owner_v;
        end
    end

    // Noise estimate from idle buttons, peak hold with slow decay
    always_comb begin
        next_noise = (noise_est != 16'h0000) ? noise_est - 16'h0001 : 16'h0000;
        for (int i = 0; i < N; i++) begin
            if (touch_pkg::BUTTON_MASK[i] && !det[i] && diff[i] > next_noise)
                next_noise = diff[i];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) noise_est <= 16'h0000;
        else if (i_scan_done && auto_active && phase == PH_RUN) noise_est <= next_noise;
    end

    // Latched activations; a new set beats the read clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) latched <= 8'h00;
        else latched <= (latched & ~(latch_rd ? 8'hff : 8'h00))
                        | (i_scan_done ? (next_stat & ~cur_stat) : 8'h00);
    end

    // Host interrupt: active low pulse on any status change, at most one per scan
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) int_cnt <= 8'h00;
        else if (i_scan_done && next_stat != cur_stat) int_cnt <= touch_pkg::HOST_INT_CYCLES;
        else if (int_cnt != 8'h00) int_cnt <= int_cnt - 8'h01;
    end

    // Registered pin outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_host_int_n <= 1'b1;
            o_general_output_pin <= 8'h00;
        end else begin
            o_host_int_n <= (int_cnt == 8'h00);
            for (int i = 0; i < N; i++)
                o_general_output_pin[i] <= cur_stat[i] || (hold_cnt[i] != 7'h00);
        end
    end

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_change;
        i_scan_done && (next_stat != cur_stat);
    endsequence

    chk_noise_excl: assert property (ctrl[touch_pkg::CTRL_NOISE_IMM] |-> !auto_active)
        else $error("auto threshold active with noise immunity on");
    chk_supp_single: assert property ($onehot0(reported & adjacent_touch_suppression))
        else $error("more than one suppressed button reported");
    chk_guard_keep: assert property (!arst_fire[touch_pkg::GUARD_IDX])
        else $error("guard sensor auto reset");
    chk_arst_off: assert property (arst_fire[0] |=> !det_q[0] && !reported[0])
        else $error("sensor still active after auto reset");
    chk_latch_set: assert property (i_scan_done && next_stat[0] && !cur_stat[0]
        |=> latched[0] && cur_stat[0])
        else $error("activation not latched");
    chk_int_pulse: assert property (s_change |=> ##1 !o_host_int_n [*8])
        else $error("no host interrupt pulse on change");
    chk_hold_load: assert property ((hold_cnt[0] > $past(hold_cnt[0]))
        |-> !$past(arst_fire[0]) && !$past(toggle_en[0]))
        else $error("hold started after reset or in toggle mode");
    chk_seq_live: assert property ($past(i_rst_n) |-> |lfsr && lfsr != $past(lfsr))
        else $error("sense sequence stuck");
    chk_prox_thr: assert property (thr[6] == sens_thr(sens_cfg[13:12]))
        else $error("proximity threshold not from sensitivity");
endmodule : touch_status_postprocess
`default_nettype wire

// File: dv/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Clock
    input wire logic i_clk,
    // Register port towards the block
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    input wire logic [31:0] i_rdata,
    // Interrupt line from the block
    input wire logic i_host_int_n
);
    int int_count = 0;
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Count interrupt pulses seen by the host
    always @(negedge i_host_int_n) int_count++;
    // One-cycle write; idle bus shows inverted leftovers, never stale data
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : wr
    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask : rd
endmodule : host_model
`default_nettype wire

// File: dv/touch_status_postprocess_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin failures++; \
    $display("mismatch at %0t: got %h want %h", $time, act, exp); end end
module touch_status_postprocess_tb;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_scan_done = 1'b0;
    logic [127:0] i_raw_count = '0;
    logic [7:0] addr, gen_out;
    logic [31:0] wdata, rdata, rd_v;
    logic wr, rd, sense_clk, nim, int_n;
    int failures = 0, cmp_count = 0, cyc = 0, sense_flips = 0;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_s;
    // Register rows: address, written value, value read back; hold field 1 clamps to 100
    row_s rows[7] = '{'{8'h00, 32'h15, 32'h15}, '{8'h04, 32'he4, 32'he4},
        '{8'h08, 32'hffff, 32'hff3f}, '{8'h0c, 32'h1234, 32'h1234},
        '{8'h10, 32'h101, 32'h01}, '{8'h14, 32'hff05, 32'h6405},
        '{8'h3c, 32'hffffffff, 32'h0}};
    // 5 ns clock
    always #2.5 i_clk = ~i_clk;
    // Hang guard and sense clock activity
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            end_sim();
        end
    end
    always @(posedge sense_clk) sense_flips++;
    host_model host_model_i (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
        .o_rd(rd), .i_rdata(rdata), .i_host_int_n(int_n));
    touch_status_postprocess #(.TICK_CYCLES(20)) touch_status_postprocess_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scan_done(i_scan_done),
        .i_raw_count(i_raw_count), .o_pseudo_random_sense_clock(sense_clk),
        .o_advanced_noise_immunity_mode(nim), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_general_output_pin(gen_out),
        .o_host_int_n(int_n));
    // Scans 20 cycles apart; touched sensors sit far above baseline
    task automatic scan(input logic [7:0] touch, input int n);
        logic [127:0] r;
        for (int i = 0; i < 8; i++) r[16*i +: 16] = touch[i] ? 16'h0d00 : 16'h0100;
        repeat (n) begin
            repeat (19) @(posedge i_clk);
            i_scan_done <= 1'b1;
            i_raw_count <= r;
            @(posedge i_clk);
            i_scan_done <= 1'b0;
        end
    endtask : scan
    task automatic stat(input logic [7:0] e);
        host_model_i.rd(touch_pkg::ADDR_STAT, rd_v);
        `CHK(rd_v[7:0], e)
    endtask : stat
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        host_model_i.rd(touch_pkg::ADDR_CTRL, rd_v);
        `CHK(rd_v[4:0], touch_pkg::CTRL_RESET)
        `CHK(int_n, 1'b1)
        foreach (rows[k]) begin
            host_model_i.wr(rows[k].a, rows[k].w);
            host_model_i.rd(rows[k].a, rd_v);
            `CHK(rd_v, rows[k].e)
        end
        // Noise immunity forces auto threshold off
        host_model_i.wr(touch_pkg::ADDR_CTRL, 32'h3);
        host_model_i.rd(touch_pkg::ADDR_NOISE, rd_v);
        `CHK(rd_v[16], 1'b0)
        `CHK(nim, 1'b1)
        host_model_i.wr(touch_pkg::ADDR_CTRL, 32'h1);
        host_model_i.rd(touch_pkg::ADDR_NOISE, rd_v);
        `CHK(rd_v[16], 1'b1)
        host_model_i.wr(touch_pkg::ADDR_SENS, 32'h0);
        host_model_i.wr(touch_pkg::ADDR_FEAT, 32'h0403);
        // Buttons 0 and 1 suppressed together, button 2 toggles, guard held
        scan(8'h00, 4);
        scan(8'h87, 6);
        stat(8'h85);
        `CHK(gen_out, 8'h85)
        `CHK(host_model_i.int_count > 0, 1'b1)
        host_model_i.rd(touch_pkg::ADDR_LATCH, rd_v);
        `CHK(rd_v[7:0], 8'h85)
        host_model_i.rd(touch_pkg::ADDR_LATCH, rd_v);
        `CHK(rd_v[7:0], 8'h00)
        // Release of the toggle sensor keeps its status
        scan(8'h83, 6);
        stat(8'h85);
        // Stuck touch: still on well before 5 s, off after it, guard exempt
        scan(8'h83, 100);
        stat(8'h85);
        scan(8'h83, 160);
        stat(8'h84);
        `CHK(gen_out, 8'h84)
        // Hold-on: after release the output outlives the status by 5 ticks only
        scan(8'h80, 30);
        scan(8'h81, 4);
        stat(8'h85);
        for (int k = 0; k < 40 && rd_v[0]; k++) begin
            scan(8'h80, 1);
            host_model_i.rd(touch_pkg::ADDR_STAT, rd_v);
        end
        `CHK({rd_v[0], gen_out[0]}, 2'b01)
        scan(8'h80, 7);
        `CHK(gen_out, 8'h84)
        // Mid-run reset clears outputs and the unread latch
        i_rst_n <= 1'b0;
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        `CHK({gen_out, int_n, nim}, 10'h002)
        host_model_i.rd(touch_pkg::ADDR_LATCH, rd_v);
        `CHK(rd_v, 32'h0)
        `CHK(sense_flips > 10, 1'b1)
        end_sim();
    end
endmodule : touch_status_postprocess_tb
`default_nettype wire
